/* File: adcr_fifo.sv */
// Result FIFO between the converter core and the output register
`timescale 1ns/100ps
module adcr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  // Count is one bit wider than the pointers, so full fits
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Flags come from flops so the ready port is registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL_CNT);
      out_valid <= (cnt_d != '0);
    end
  end
endmodule : adcr_fifo

/* File: adcr_host_model.sv */
// Host model that clocks serial results out in external mode
`timescale 1ns/100ps
module adcr_host_model (
  // Clock
  input wire logic clk,
  // Frame request and serial line
  input wire logic go,
  input wire logic serial_result_out,
  // Host clock and collected word
  output logic host_clock,
  output logic [15:0] word,
  output logic done
);
  initial begin
    host_clock = 1'b0;
    word = 16'h0000;
    done = 1'b0;
  end
  // Clock stands low outside frames; 160 ns period
  always @(posedge go) begin
    done = 1'b0;
    for (int k = 0; k <= 16; k++) begin
      repeat (4) @(negedge clk);
      // Sample late in the low phase, first edge holds the top bit
      if (k > 0) word[16-k] = serial_result_out;
      if (k < 16) begin
        host_clock = 1'b1;
        repeat (4) @(negedge clk);
        host_clock = 1'b0;
      end
    end
    done = 1'b1;
  end
endmodule : adcr_host_model

/* File: adcr_pkg.sv */
// Shared constants and types for the converter result read-out block
package adcr_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RES_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 11;
  localparam int BIT_CNT_W = 5;
  // Conversion time, least figure
  localparam int CONV_TIME_NS = 19000;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Start of conversion to first internal shift clock
  localparam int CLK_DLY_NS = 1400;
  localparam int CLK_DLY_CYC = (CLK_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Internal shift clock period, each half rounded down
  localparam int SCLK_PER_NS = 1100;
  localparam int SCLK_HALF_CYC = SCLK_PER_NS / 2 / CLK_PERIOD_NS;
  localparam int SER_BITS = 16;
  localparam logic [RES_W-1:0] OUT_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BUS_RST = 8'h00;
  // Synchroniser lane positions
  localparam int SY_CS = 0;
  localparam int SY_RD = 1;
  localparam int SY_BYTE = 2;
  localparam int SY_FMT = 3;
  localparam int SY_SRC = 4;
  localparam int SY_SCLK = 5;
  localparam int SY_W = 6;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_SETTLE = 4'b1000
  } adcr_state_t;
endpackage : adcr_pkg

/* File: adcr_readout.sv */
// Result read-out of a 16-bit converter: format, parallel bytes, serial
//
// Overview of operation
// - Format input high: straight binary, low: twos complement
// - First result after power-up is meaningless
// - Parallel read never alters the output register
// - Each serial clock shifts register one bit, except the first external rising edge
// - Internal mode: start drives clock, sends previous result
// - External mode: clock pin input, conversion self-timed
// - External mode after conversion: host clocks result out
// - External mode during conversion: previous result clocked
// - Convert commands ignored while busy low
// - Twos complement codes 7fff, 0000, ffff, 8000
// - Straight binary codes ffff, 8000, 7fff, 0000
// - Bus driven only when reading and selected
// - Byte select low upper byte, high lower
// - Byte select may toggle freely within cycle
// - Output register undefined until first conversion; here reset loads 0000
// - Register updated before busy rises
// - Start is level OR of active-low selects
// - Busy low from start until result stored
// - Internal mode sends 16 pulses, MSB first
`timescale 1ns/100ps
module adcr_readout #(
  parameter int CONV_CYCLES = adcr_pkg::CONV_CYC,
  parameter int FIFO_DEPTH = adcr_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host control pins
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic code_format_select,
  input wire logic clock_source_select,
  // Shift clock pin, two-way
  input wire logic shift_clock_in,
  output logic shift_clock_out,
  output logic shift_clock_oe,
  // Serial and parallel results
  output logic serial_result_out,
  output logic [adcr_pkg::BYTE_W-1:0] result_bus_out,
  output logic result_bus_oe,
  output logic busy,
  // Converter core results, twos complement
  input wire logic core_valid,
  output logic core_ready,
  input wire logic [adcr_pkg::RES_W-1:0] core_code
);
  import adcr_pkg::*;

  // Straight binary is the offset form of twos complement
  function automatic logic [RES_W-1:0] fmt_code(input logic [RES_W-1:0] c,
                                                input logic sb);
    fmt_code = {c[RES_W-1] ^ sb, c[RES_W-2:0]};
  endfunction : fmt_code

  logic [SY_W-1:0] sy1_q;
  logic [SY_W-1:0] sy2_q;
  logic sclk_dly_q;
  logic cs_s;
  logic rd_s;
  logic byte_s;
  logic fmt_s;
  logic src_s;
  logic sclk_rise;
  adcr_state_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic start;
  logic load;
  logic [RES_W-1:0] out_q;
  logic [RES_W-1:0] out_fmt;
  logic fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic int_run_q;
  logic int_sclk_q;
  logic [CNT_W-1:0] int_tmr_q;
  logic [BIT_CNT_W-1:0] int_left_q;
  logic int_shift;
  logic ext_en;
  logic ext_first_q;
  logic ext_shift;
  logic fresh_q;

  // Pins pass two flops; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sclk_dly_q <= 1'b0;
    end else begin
      sy1_q <= {shift_clock_in, clock_source_select, code_format_select,
                byte_select, read_convert, chip_select_n};
      sy2_q <= sy1_q;
      sclk_dly_q <= sy2_q[SY_SCLK];
    end
  end

  assign cs_s = sy2_q[SY_CS];
  assign rd_s = sy2_q[SY_RD];
  assign byte_s = sy2_q[SY_BYTE];
  assign fmt_s = sy2_q[SY_FMT];
  assign src_s = sy2_q[SY_SRC];
  assign sclk_rise = sy2_q[SY_SCLK] && !sclk_dly_q;

  // Level start, only sampled while idle
  assign start = (st_q == ST_IDLE) && !cs_s && !rd_s;
  assign load = (st_q == ST_LOAD) && fifo_valid;

  adcr_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(core_valid),
    .in_ready(core_ready),
    .in_data(core_code),
    .out_valid(fifo_valid),
    .out_ready(load),
    .out_data(fifo_data)
  );

  // Conversion sequencer on the internal clock in both modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_CONV;
            cnt_q <= CNT_W'(CONV_CYCLES - 1);
          end
        end
        ST_CONV: begin
          if (cnt_q == '0) begin
            st_q <= ST_LOAD;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        // An empty core FIFO stalls the conversion end
        ST_LOAD: begin
          if (fifo_valid) begin
            st_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Busy falls on start, rises one cycle after the register load, on the same edge that refreshes the bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b1;
    end else if (start) begin
      busy <= 1'b0;
    end else if (st_q == ST_SETTLE) begin
      busy <= 1'b1;
    end
  end

  // Internal shift clock; the timer doubles as the rate divider
  assign int_shift = int_run_q && int_tmr_q == '0 && int_sclk_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_run_q <= 1'b0;
      int_sclk_q <= 1'b0;
      int_tmr_q <= '0;
      int_left_q <= '0;
    end else if (start && !src_s) begin
      int_run_q <= 1'b1;
      int_sclk_q <= 1'b0;
      int_tmr_q <= CNT_W'(CLK_DLY_CYC - 1);
      int_left_q <= BIT_CNT_W'(SER_BITS);
    end else if (int_run_q) begin
      if (int_tmr_q != '0) begin
        int_tmr_q <= int_tmr_q - CNT_W'(1);
      end else begin
        int_tmr_q <= CNT_W'(SCLK_HALF_CYC - 1);
        if (int_sclk_q) begin
          int_sclk_q <= 1'b0;
          int_left_q <= int_left_q - BIT_CNT_W'(1);
        end else if (int_left_q == '0) begin
          int_run_q <= 1'b0;
        end else begin
          int_sclk_q <= 1'b1;
        end
      end
    end
  end

  // External clock: MSB holds over the first rising edge
  assign ext_en = src_s && !cs_s && rd_s;
  assign ext_shift = ext_en && sclk_rise && !ext_first_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_first_q <= 1'b1;
    end else if (!ext_en) begin
      ext_first_q <= 1'b1;
    end else if (sclk_rise) begin
      ext_first_q <= 1'b0;
    end
  end

  // Output register: loading beats shifting, so a late clock loses a bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q <= OUT_RST;
    end else if (load) begin
      out_q <= fifo_data;
    end else if (int_shift || ext_shift) begin
      out_q <= {out_q[RES_W-2:0], 1'b0};
    end
  end

  // Only the stored top bit is inverted; shifted bits keep their value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fresh_q <= 1'b1;
    end else if (load) begin
      fresh_q <= 1'b1;
    end else if (int_shift || ext_shift) begin
      fresh_q <= 1'b0;
    end
  end

  assign out_fmt = fmt_code(out_q, fmt_s);

  // Pin drivers, all registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_bus_out <= BUS_RST;
      result_bus_oe <= 1'b0;
      serial_result_out <= 1'b0;
      shift_clock_out <= 1'b0;
      shift_clock_oe <= 1'b0;
    end else begin
      result_bus_oe <= !cs_s && rd_s;
      result_bus_out <= byte_s ? out_fmt[BYTE_W-1:0] :
                        out_fmt[RES_W-1:BYTE_W];
      serial_result_out <= out_q[RES_W-1] ^ (fmt_s && fresh_q);
      shift_clock_out <= int_sclk_q;
      shift_clock_oe <= !src_s;
    end
  end

  // Checking helpers
  logic [BIT_CNT_W:0] pulse_cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n || (start && !src_s)) begin
      pulse_cnt_q <= '0;
    end else if (int_sclk_q && !shift_clock_out) begin
      pulse_cnt_q <= pulse_cnt_q + (BIT_CNT_W+1)'(1);
    end
  end

  chk_bus_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (!cs_s && rd_s) ##1 (!cs_s && rd_s) |-> result_bus_oe)
    else $error("bus not driven while read selected");

  chk_bus_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cs_s || !rd_s) |-> !result_bus_oe)
    else $error("bus driven while not read selected");

  chk_byte_pick: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(out_q) && $stable(fmt_s) |=>
    result_bus_out == ($past(byte_s) ? $past(out_fmt[7:0]) :
    $past(out_fmt[15:8])))
    else $error("wrong byte on result bus");

  chk_par_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !load && !int_shift && !ext_shift |=> $stable(out_q))
    else $error("output register changed without load or shift");

  chk_shift_step: assert property (@(posedge clk) disable iff (!rst_n)
    (int_shift || ext_shift) && !load |=>
    out_q == {$past(out_q[14:0]), 1'b0})
    else $error("serial clock did not shift one place");

  chk_format_msb: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 serial_result_out ==
    ($past(out_q[15]) ^ ($past(fmt_s) && $past(fresh_q))))
    else $error("serial bit in wrong code format");

  chk_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    !busy && st_q == ST_CONV && cnt_q > 11'd1 |=> st_q == ST_CONV)
    else $error("conversion disturbed while busy low");

  chk_busy_after_load: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy) |-> $past(load, 2))
    else $error("busy rose before register update");

  chk_busy_low: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> !busy [*8])
    else $error("busy did not stay low after start");

  chk_start_level: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_IDLE && !cs_s && !rd_s |=> !busy && st_q == ST_CONV)
    else $error("level start not taken");

  chk_pulse_count: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(int_run_q) |-> pulse_cnt_q == 6'd16)
    else $error("internal clock pulse count not sixteen");

  chk_int_drive: assert property (@(posedge clk) disable iff (!rst_n)
    start && !src_s |=> ##1 shift_clock_oe ##[1:80] shift_clock_out)
    else $error("internal clock not driven after start");

  chk_ext_input: assert property (@(posedge clk) disable iff (!rst_n)
    src_s && $past(src_s) |=> !shift_clock_oe)
    else $error("shift clock driven in external mode");

  cov_int_frame: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(int_run_q) && pulse_cnt_q == 6'd16);
  cov_ext_shift: cover property (@(posedge clk) disable iff (!rst_n)
    ext_shift && !busy);
  cov_byte_swap: cover property (@(posedge clk) disable iff (!rst_n)
    result_bus_oe && $changed(byte_s));
  cov_fifo_full: cover property (@(posedge clk) disable iff (!rst_n)
    !core_ready);
endmodule : adcr_readout

/* File: tb_adcr_readout.sv */
// Self-checking bench for the converter result read-out
`timescale 1ns/100ps
module tb_adcr_readout;
  import adcr_pkg::*;
  localparam int CONV = 950;
  localparam logic [15:0] CODES [4] = '{16'h7fff, 16'h0000, 16'hffff,
                                       16'h8000};
  logic clk, rst_n, cs_n, rc, bsel, fmt, src, go, done, hclk, pin;
  logic sco, scoe, sro, bus_oe, busy, cvalid, cready;
  logic [BYTE_W-1:0] bus;
  logic [RES_W-1:0] ccode, word, ibits;
  int n_errors, comparisons, ipulses, nfill, n;
  // Shared clock pin: device drives it only while enabled
  assign pin = scoe ? sco : hclk;
  adcr_readout #(.CONV_CYCLES(CONV), .FIFO_DEPTH(8)) i_adcr_readout (
    .clk(clk), .rst_n(rst_n), .chip_select_n(cs_n), .read_convert(rc),
    .byte_select(bsel), .code_format_select(fmt),
    .clock_source_select(src), .shift_clock_in(pin),
    .shift_clock_out(sco), .shift_clock_oe(scoe),
    .serial_result_out(sro), .result_bus_out(bus),
    .result_bus_oe(bus_oe), .busy(busy), .core_valid(cvalid),
    .core_ready(cready), .core_code(ccode));
  adcr_host_model i_adcr_host_model (.clk(clk), .go(go),
    .serial_result_out(sro), .host_clock(hclk), .word(word),
    .done(done));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Data changes as the clock falls, so take it on the rise
  always @(posedge sco) begin
    ibits = {ibits[14:0], sro};
    ipulses++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic conv(input logic s);
    src = s;
    ipulses = 0;
    n = 0;
    repeat (4) @(negedge clk);
    cs_n = 1'b0;
    rc = 1'b0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(bus_oe, 1'b0);
    repeat (5) @(negedge clk);
    cs_n = 1'b1;
    rc = 1'b1;
    // Second start while busy is low must not stretch the conversion
    repeat (20) @(negedge clk);
    cs_n = 1'b0;
    rc = 1'b0;
    repeat (5) @(negedge clk);
    cs_n = 1'b1;
    rc = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(n > CONV - 45 && n < CONV - 15, 1'b1);
    $display("Conversion test done");
  endtask : conv
  task automatic rd(input logic b, input logic f, input logic [7:0] e);
    cs_n = 1'b0;
    rc = 1'b1;
    bsel = b;
    fmt = f;
    repeat (4) @(negedge clk);
    check(bus_oe, 1'b1);
    check(bus, e);
  endtask : rd
  task automatic rd_all(input logic [15:0] c);
    logic [15:0] e;
    for (int f = 0; f < 2; f++) begin
      e = f ? c ^ 16'h8000 : c;
      rd(1'b0, f[0], e[15:8]);
      rd(1'b1, f[0], e[7:0]);
      rd(1'b0, f[0], e[15:8]);
    end
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    check(bus_oe, 1'b0);
    $display("Parallel read test done");
  endtask : rd_all
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    {cs_n, rc, bsel, fmt, src, go, cvalid} = 7'b1100100;
    ccode = 16'h0000;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Fill the result FIFO until it refuses
    cvalid = 1'b1;
    for (int i = 0; i < 12 && cready === 1'b1; i++) begin
      ccode = CODES[i%4];
      @(negedge clk);
      nfill++;
    end
    cvalid = 1'b0;
    check(nfill, 16'd8);
    for (int i = 0; i < 3; i++) begin
      conv(1'b1);
      rd_all(CODES[i]);
    end
    fmt = 1'b1;
    conv(1'b0);
    check(scoe, 1'b1);
    check(ipulses, 16'd16);
    check(ibits, 16'h7fff);
    rd_all(CODES[3]);
    src = 1'b1;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    go = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    go = 1'b0;
    check(word, 16'h0000);
    rd(1'b0, 1'b0, 8'h00);
    $display("Serial read test done");
    end_sim();
  end
endmodule : tb_adcr_readout
